// [logic/panel_address_mode_control.v]
// Function
// - Switch bit1 debug, bit2 mode select
// - Latch switch only at restart
// - Configuration state shows config code
// - Debug state shows debug code
// - Master, slave, generic serial modes
// - Running shows decimal slave address
// - Double press edits flashing high digit
// - Three second hold moves to low
// - Accepted address flashes three times
// - Ten idle seconds discards edit
// - Address limited to 0 through 99
// - Fault LED steady on bus fail
// - Activity LED blinks during exchange
// - Differential port tx/rx LEDs blink
// - Single-ended port tx/rx LEDs blink
// - Drive fieldbus request-to-send line
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "panel_defs.vh"

module panel_address_mode_control #(
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_MS * `CLK_KHZ,
  parameter DOUBLE_WIN_CYCLES = `DOUBLE_WIN_MS * `CLK_KHZ,
  parameter HOLD_CYCLES = `HOLD_MS * `CLK_KHZ,
  parameter IDLE_CYCLES = `IDLE_MS * `CLK_KHZ,
  parameter BLINK_CYCLES = `BLINK_MS * `CLK_KHZ,
  parameter FLASH_CYCLES = `FLASH_MS * `CLK_KHZ
) (
  input wire ref_clk,
  input wire rst,
  input wire switch_debug,
  input wire switch_mode,
  input wire button,
  input wire fieldbus_fail,
  input wire fieldbus_exchange,
  input wire fieldbus_tx_dir,
  input wire diff_tx_busy,
  input wire diff_rx_busy,
  input wire se_tx_busy,
  input wire se_rx_busy,
  output reg [6:0] seg_hi,
  output reg [6:0] seg_lo,
  output reg fieldbus_fault_led,
  output reg fieldbus_activity_led,
  output reg diff_tx_led,
  output reg diff_rx_led,
  output reg se_tx_led,
  output reg se_rx_led,
  output reg fieldbus_rts,
  output reg [1:0] op_state,
  output reg [1:0] serial_mode,
  output reg [6:0] slave_address,
  output reg irq,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  localparam [`CNT_W-1:0] DEB_LAST = DEBOUNCE_CYCLES - 1;
  localparam [`CNT_W-1:0] WIN_LAST = DOUBLE_WIN_CYCLES - 1;
  localparam [`CNT_W-1:0] HOLD_LAST = HOLD_CYCLES - 1;
  localparam [`CNT_W-1:0] IDLE_LAST = IDLE_CYCLES - 1;
  localparam [`CNT_W-1:0] BLINK_LAST = BLINK_CYCLES - 1;
  localparam [`CNT_W-1:0] FLASH_LAST = FLASH_CYCLES - 1;
  localparam integer CONF_HALVES = 2 * `CONFIRM_FLASHES;
  localparam [2:0] FLASH_HALVES = CONF_HALVES[2:0];

  localparam [1:0] E_IDLE = 2'h0;
  localparam [1:0] E_HI = 2'h1;
  localparam [1:0] E_LO = 2'h2;
  localparam [1:0] E_CONF = 2'h3;

  function [6:0] seg_of;
    input [3:0] digit;
    begin
      case (digit)
        4'h0: seg_of = 7'h3f;
        4'h1: seg_of = 7'h06;
        4'h2: seg_of = 7'h5b;
        4'h3: seg_of = 7'h4f;
        4'h4: seg_of = 7'h66;
        4'h5: seg_of = 7'h6d;
        4'h6: seg_of = 7'h7d;
        4'h7: seg_of = 7'h07;
        4'h8: seg_of = 7'h7f;
        4'h9: seg_of = 7'h6f;
        default: seg_of = `SEG_BLANK;
      endcase
    end
  endfunction

  // Wraps 9 back to 0 so a digit never leaves decimal
  function [3:0] inc_digit;
    input [3:0] digit;
    begin
      inc_digit = (digit >= 4'h9) ? 4'h0 : digit + 4'h1;
    end
  endfunction

  // ----------------------------------------
  // Mode latch
  // ----------------------------------------
  reg mode_taken;
  always @(posedge ref_clk) begin
    if (rst) begin
      mode_taken <= 1'b0;
      op_state <= `OP_RUN;
    end else if (!mode_taken) begin
      mode_taken <= 1'b1;
      if (switch_mode && !switch_debug)
        op_state <= `OP_CONFIG;
      else if (switch_debug && !switch_mode)
        op_state <= `OP_DEBUG;
      else
        op_state <= `OP_RUN;
    end
  end

  // ----------------------------------------
  // Button debounce and press classifier
  // ----------------------------------------
  reg btn_db;
  reg btn_prev;
  reg [`CNT_W-1:0] deb_cnt;
  reg [`CNT_W-1:0] hold_cnt;
  reg [`CNT_W-1:0] win_cnt;
  reg long_done;
  reg pending;
  reg ev_single;
  reg ev_double;
  reg ev_long;

  always @(posedge ref_clk) begin
    if (rst) begin
      btn_db <= 1'b0;
      btn_prev <= 1'b0;
      deb_cnt <= {`CNT_W{1'b0}};
      hold_cnt <= {`CNT_W{1'b0}};
      win_cnt <= {`CNT_W{1'b0}};
      long_done <= 1'b0;
      pending <= 1'b0;
      ev_single <= 1'b0;
      ev_double <= 1'b0;
      ev_long <= 1'b0;
    end else begin
      ev_single <= 1'b0;
      ev_double <= 1'b0;
      ev_long <= 1'b0;
      btn_prev <= btn_db;
      if (button == btn_db)
        deb_cnt <= {`CNT_W{1'b0}};
      else if (deb_cnt >= DEB_LAST) begin
        deb_cnt <= {`CNT_W{1'b0}};
        btn_db <= button;
      end else
        deb_cnt <= deb_cnt + 1'b1;
      if (!btn_db) begin
        hold_cnt <= {`CNT_W{1'b0}};
        long_done <= 1'b0;
      end else if (!long_done) begin
        if (hold_cnt >= HOLD_LAST) begin
          ev_long <= 1'b1;
          long_done <= 1'b1;
          pending <= 1'b0;
        end else
          hold_cnt <= hold_cnt + 1'b1;
      end
      if (btn_prev && !btn_db && !long_done) begin
        if (pending) begin
          ev_double <= 1'b1;
          pending <= 1'b0;
        end else begin
          pending <= 1'b1;
          win_cnt <= {`CNT_W{1'b0}};
        end
      end else if (pending && !btn_db) begin
        if (win_cnt >= WIN_LAST) begin
          ev_single <= 1'b1;
          pending <= 1'b0;
        end else
          win_cnt <= win_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Address editing
  // ----------------------------------------
  reg [1:0] edit_state;
  reg [3:0] addr_hi;
  reg [3:0] addr_lo;
  reg [3:0] edit_hi;
  reg [3:0] edit_lo;
  reg [`CNT_W-1:0] idle_cnt;
  reg [`CNT_W-1:0] flash_cnt;
  reg [2:0] flash_halves;
  reg flash_on;
  reg ev_stored;
  reg ev_timeout;
  wire btn_activity = btn_db ^ btn_prev;

  always @(posedge ref_clk) begin
    if (rst) begin
      edit_state <= E_IDLE;
      addr_hi <= 4'h0;
      addr_lo <= 4'h0;
      edit_hi <= 4'h0;
      edit_lo <= 4'h0;
      idle_cnt <= {`CNT_W{1'b0}};
      flash_cnt <= {`CNT_W{1'b0}};
      flash_halves <= 3'h0;
      flash_on <= 1'b0;
      ev_stored <= 1'b0;
      ev_timeout <= 1'b0;
    end else begin
      ev_stored <= 1'b0;
      ev_timeout <= 1'b0;
      if (flash_cnt >= FLASH_LAST) begin
        flash_cnt <= {`CNT_W{1'b0}};
        flash_on <= ~flash_on;
      end else
        flash_cnt <= flash_cnt + 1'b1;
      if (btn_activity || edit_state == E_IDLE || edit_state == E_CONF)
        idle_cnt <= {`CNT_W{1'b0}};
      else
        idle_cnt <= idle_cnt + 1'b1;
      case (edit_state)
        E_IDLE: begin
          if (ev_double && op_state == `OP_RUN) begin
            edit_state <= E_HI;
            edit_hi <= addr_hi;
            edit_lo <= addr_lo;
            flash_cnt <= {`CNT_W{1'b0}};
            flash_on <= 1'b0;
          end
        end
        E_HI, E_LO: begin
          if (idle_cnt >= IDLE_LAST) begin
            edit_state <= E_IDLE;
            ev_timeout <= 1'b1;
          end else if (ev_long && edit_state == E_HI)
            edit_state <= E_LO;
          else if (ev_long) begin
            addr_hi <= edit_hi;
            addr_lo <= edit_lo;
            edit_state <= E_CONF;
            ev_stored <= 1'b1;
            flash_halves <= 3'h0;
            flash_cnt <= {`CNT_W{1'b0}};
            flash_on <= 1'b0;
          end else if (ev_single || ev_double) begin
            if (edit_state == E_HI)
              edit_hi <= ev_double ? inc_digit(inc_digit(edit_hi))
                                   : inc_digit(edit_hi);
            else
              edit_lo <= ev_double ? inc_digit(inc_digit(edit_lo))
                                   : inc_digit(edit_lo);
          end
        end
        E_CONF: begin
          if (flash_cnt >= FLASH_LAST) begin
            if (flash_halves >= FLASH_HALVES - 3'h1)
              edit_state <= E_IDLE;
            else
              flash_halves <= flash_halves + 3'h1;
          end
        end
        default: edit_state <= E_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Display and indicators
  // ----------------------------------------
  reg [`CNT_W-1:0] blink_cnt;
  reg blink_on;

  always @(posedge ref_clk) begin
    if (rst) begin
      blink_cnt <= {`CNT_W{1'b0}};
      blink_on <= 1'b0;
      seg_hi <= `SEG_BLANK;
      seg_lo <= `SEG_BLANK;
      fieldbus_fault_led <= 1'b0;
      fieldbus_activity_led <= 1'b0;
      diff_tx_led <= 1'b0;
      diff_rx_led <= 1'b0;
      se_tx_led <= 1'b0;
      se_rx_led <= 1'b0;
      fieldbus_rts <= 1'b0;
      slave_address <= 7'h00;
    end else begin
      if (blink_cnt >= BLINK_LAST) begin
        blink_cnt <= {`CNT_W{1'b0}};
        blink_on <= ~blink_on;
      end else
        blink_cnt <= blink_cnt + 1'b1;
      slave_address <= addr_hi * 7'h0a + {3'h0, addr_lo};
      if (op_state == `OP_CONFIG) begin
        seg_hi <= `SEG_C;
        seg_lo <= `SEG_F;
      end else if (op_state == `OP_DEBUG) begin
        seg_hi <= `SEG_D;
        seg_lo <= `SEG_B;
      end else begin
        case (edit_state)
          E_HI: begin
            seg_hi <= flash_on ? seg_of(edit_hi) : `SEG_BLANK;
            seg_lo <= seg_of(edit_lo);
          end
          E_LO: begin
            seg_hi <= seg_of(edit_hi);
            seg_lo <= flash_on ? seg_of(edit_lo) : `SEG_BLANK;
          end
          E_CONF: begin
            seg_hi <= flash_on ? seg_of(addr_hi) : `SEG_BLANK;
            seg_lo <= flash_on ? seg_of(addr_lo) : `SEG_BLANK;
          end
          default: begin
            seg_hi <= seg_of(addr_hi);
            seg_lo <= seg_of(addr_lo);
          end
        endcase
      end
      fieldbus_fault_led <= fieldbus_fail;
      fieldbus_activity_led <= fieldbus_exchange & blink_on;
      diff_tx_led <= diff_tx_busy & blink_on;
      diff_rx_led <= diff_rx_busy & blink_on;
      se_tx_led <= se_tx_busy & blink_on;
      se_rx_led <= se_rx_busy & blink_on;
      fieldbus_rts <= fieldbus_tx_dir;
    end
  end

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  reg aw_full;
  reg w_full;
  reg [3:0] aw_idx;
  reg aw_bad;
  reg [7:0] w_byte0;
  reg w_en0;
  reg [`IRQ_W-1:0] irq_status;
  reg [`IRQ_W-1:0] irq_mask;
  reg bus_fail_prev;
  wire [3:0] ar_idx = s_axi_araddr[`REG_IDX_MSB:`REG_IDX_LSB];
  wire ar_ok = s_axi_araddr[31:`REG_IDX_MSB+1] == 0 &&
    s_axi_araddr[1:0] == 2'h0 && ar_idx <= `REG_IRQ_MASK;
  wire rd_take = s_axi_arvalid & s_axi_arready;
  wire wr_do = aw_full & w_full & ~s_axi_bvalid;
  wire [`IRQ_W-1:0] irq_events = {fieldbus_fail & ~bus_fail_prev,
    ev_timeout, ev_stored};
  wire irq_clear = rd_take && ar_ok && ar_idx == `REG_IRQ_STATUS;

  always @(posedge ref_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_idx <= 4'h0;
      aw_bad <= 1'b0;
      w_byte0 <= 8'h00;
      w_en0 <= 1'b0;
      serial_mode <= `SER_MODE_MASTER;
      irq_mask <= {`IRQ_W{1'b0}};
      irq_status <= {`IRQ_W{1'b0}};
      bus_fail_prev <= 1'b0;
      irq <= 1'b0;
    end else begin
      bus_fail_prev <= fieldbus_fail;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_idx <= s_axi_awaddr[`REG_IDX_MSB:`REG_IDX_LSB];
        aw_bad <= s_axi_awaddr[31:`REG_IDX_MSB+1] != 0 ||
          s_axi_awaddr[1:0] != 2'h0;
      end else if (!aw_full && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
        w_byte0 <= s_axi_wdata[7:0];
        w_en0 <= s_axi_wstrb[0];
      end else if (!w_full && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (wr_do) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        if (aw_bad || aw_idx > `REG_IRQ_MASK)
          s_axi_bresp <= `RESP_SLVERR;
        else if (w_en0 && aw_idx == `REG_CTRL)
          // serial mode select, code 3 ignored
          serial_mode <= (w_byte0[1:0] == 2'h3) ? serial_mode
                                                 : w_byte0[1:0];
        else if (w_en0 && aw_idx == `REG_IRQ_MASK)
          irq_mask <= w_byte0[`IRQ_W-1:0];
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ar_ok ? `RESP_OKAY : `RESP_SLVERR;
        s_axi_rdata <= 32'h0000_0000;
        if (ar_ok) begin
          case (ar_idx)
            `REG_CTRL: s_axi_rdata[1:0] <= serial_mode;
            `REG_STATE: s_axi_rdata[13:0] <= {edit_state, op_state,
              fieldbus_fail, slave_address, blink_on, pending};
            `REG_IRQ_STATUS: s_axi_rdata[`IRQ_W-1:0] <= irq_status;
            default: s_axi_rdata[`IRQ_W-1:0] <= irq_mask;
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid && !s_axi_arready)
        s_axi_arready <= 1'b1;
      // Set wins over the read clear
      irq_status <= (irq_clear ? {`IRQ_W{1'b0}} : irq_status) | irq_events;
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule // panel_address_mode_control

// [logic/panel_defs.vh]
`ifndef PANEL_DEFS_VH
`define PANEL_DEFS_VH

// Clock and times
`define CLK_KHZ 200000
`define HOLD_MS 3000
`define IDLE_MS 10000
`define DEBOUNCE_MS 10
`define DOUBLE_WIN_MS 400
`define BLINK_MS 100
`define FLASH_MS 250
`define CONFIRM_FLASHES 3
`define CNT_W 32

// Register word indexes
`define REG_CTRL 4'h0
`define REG_STATE 4'h1
`define REG_IRQ_STATUS 4'h2
`define REG_IRQ_MASK 4'h3
`define REG_IDX_LSB 2
`define REG_IDX_MSB 5

// Control register
`define CTRL_RESET 8'h00
`define SER_MODE_MASTER 2'h0
`define SER_MODE_SLAVE 2'h1
`define SER_MODE_GENERIC 2'h2

// Operating states
`define OP_RUN 2'h0
`define OP_DEBUG 2'h1
`define OP_CONFIG 2'h2

// Interrupt bits
`define IRQ_W 3
`define IRQ_STORED 0
`define IRQ_TIMEOUT 1
`define IRQ_BUS_FAIL 2

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Segment patterns, gfedcba, high lit
`define SEG_C 7'h39
`define SEG_F 7'h71
`define SEG_D 7'h5e
`define SEG_B 7'h7c
`define SEG_BLANK 7'h00

`endif

// [dv/panel_chk.sv]
`timescale 1ns/100ps
`include "panel_defs.vh"

module panel_chk (
  input wire ref_clk,
  input wire rst,
  input wire switch_debug,
  input wire switch_mode,
  input wire fieldbus_fail,
  input wire fieldbus_exchange,
  input wire fieldbus_tx_dir,
  input wire diff_rx_busy,
  input wire se_tx_busy,
  input wire [6:0] seg_hi,
  input wire [6:0] seg_lo,
  input wire fieldbus_fault_led,
  input wire fieldbus_activity_led,
  input wire diff_rx_led,
  input wire se_tx_led,
  input wire fieldbus_rts,
  input wire [1:0] op_state,
  input wire [6:0] slave_address
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ----
  // Panel checks
  // ----
  // fault follows fail
  property p_fault;
    !$past(rst) |-> fieldbus_fault_led == $past(fieldbus_fail);
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault led wrong");
  property p_act_off;
    !fieldbus_exchange |=> !fieldbus_activity_led;
  endproperty
  a_act_off: assert property (p_act_off)
    else $error("activity led lit while idle");
  property p_drx_off;
    !diff_rx_busy |=> !diff_rx_led;
  endproperty
  a_drx_off: assert property (p_drx_off)
    else $error("diff rx led lit while idle");
  property p_stx_off;
    !se_tx_busy |=> !se_tx_led;
  endproperty
  a_stx_off: assert property (p_stx_off)
    else $error("se tx led lit while idle");
  property p_rts;
    !$past(rst) |-> fieldbus_rts == $past(fieldbus_tx_dir);
  endproperty
  a_rts: assert property (p_rts)
    else $error("rts wrong");
  property p_op_latch;
    $past(rst, 2) && !$past(rst) |-> op_state ==
      (($past(switch_mode) && !$past(switch_debug)) ? `OP_CONFIG :
      (($past(switch_debug) && !$past(switch_mode)) ? `OP_DEBUG : `OP_RUN));
  endproperty
  a_op_latch: assert property (p_op_latch)
    else $error("state not decoded from switches");
  property p_op_hold;
    !$past(rst) && !$past(rst, 2) |-> $stable(op_state);
  endproperty
  a_op_hold: assert property (p_op_hold)
    else $error("state changed while running");
  property p_cfg;
    (op_state == `OP_CONFIG) [*3] |-> seg_hi == `SEG_C && seg_lo == `SEG_F;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("config code missing");
  property p_dbg;
    (op_state == `OP_DEBUG) [*3] |-> seg_hi == `SEG_D && seg_lo == `SEG_B;
  endproperty
  a_dbg: assert property (p_dbg)
    else $error("debug code missing");
  property p_addr;
    slave_address <= 7'h63;
  endproperty
  a_addr: assert property (p_addr)
    else $error("address above limit");
endmodule // panel_chk

bind panel_address_mode_control panel_chk chk_u (.*);

// [dv/panel_operator.sv]
`timescale 1ns/100ps

module panel_operator #(
  parameter DB = 4,
  parameter HOLD = 60
) (
  input wire ref_clk,
  output reg button,
  output reg switch_debug,
  output reg switch_mode
);
  // ----
  // Operator actions
  // ----
  // contact bounce
  // Bounce shorter than debounce; must never count as a press
  task automatic push(input int n);
    button <= 1'b1;
    @(posedge ref_clk);
    button <= 1'b0;
    @(posedge ref_clk);
    button <= 1'b1;
    repeat (n) @(posedge ref_clk);
    button <= 1'b0;
    repeat (DB + 4) @(posedge ref_clk);
  endtask
  task automatic click;
    push(DB + 2);
  endtask
  task automatic dbl;
    click();
    click();
  endtask
  task automatic hold;
    push(HOLD + DB + 6);
  endtask
  initial begin
    button = 1'b0;
    switch_debug = 1'b0;
    switch_mode = 1'b0;
  end
endmodule // panel_operator

// [dv/panel_address_mode_control_tb.sv]
`timescale 1ns/100ps
`include "panel_defs.vh"

module panel_address_mode_control_tb;
  localparam DB = 4;
  localparam WIN = 20;
  localparam HOLD = 60;
  localparam IDLE = 200;
  reg ref_clk;
  reg rst;
  reg fieldbus_fail;
  reg fieldbus_tx_dir;
  reg [4:0] busy;
  wire [4:0] leds;
  wire button;
  wire switch_debug;
  wire switch_mode;
  wire [6:0] seg_hi;
  wire [6:0] seg_lo;
  wire fieldbus_fault_led;
  wire fieldbus_rts;
  wire [1:0] op_state;
  wire [1:0] serial_mode;
  wire [6:0] slave_address;
  wire irq;
  reg [31:0] s_axi_awaddr;
  reg s_axi_awvalid;
  wire s_axi_awready;
  reg [31:0] s_axi_wdata;
  reg s_axi_wvalid;
  wire s_axi_wready;
  wire [1:0] s_axi_bresp;
  wire s_axi_bvalid;
  reg s_axi_bready;
  reg [31:0] s_axi_araddr;
  reg s_axi_arvalid;
  wire s_axi_arready;
  wire [31:0] s_axi_rdata;
  wire [1:0] s_axi_rresp;
  wire s_axi_rvalid;
  reg s_axi_rready;
  reg [31:0] rd;
  reg [1:0] rs;
  int mismatches;
  int samples_checked;
  int bh, bl, rh, h;

  panel_address_mode_control #(
    .DEBOUNCE_CYCLES(DB),
    .DOUBLE_WIN_CYCLES(WIN),
    .HOLD_CYCLES(HOLD),
    .IDLE_CYCLES(IDLE),
    .BLINK_CYCLES(4),
    .FLASH_CYCLES(5)
  ) dut_u (
    .*,
    .s_axi_wstrb(4'hf),
    .diff_tx_busy(busy[0]),
    .diff_rx_busy(busy[1]),
    .se_tx_busy(busy[2]),
    .se_rx_busy(busy[3]),
    .fieldbus_exchange(busy[4]),
    .diff_tx_led(leds[0]),
    .diff_rx_led(leds[1]),
    .se_tx_led(leds[2]),
    .se_rx_led(leds[3]),
    .fieldbus_activity_led(leds[4])
  );

  panel_operator #(.DB(DB), .HOLD(HOLD)) op_u (
    .ref_clk(ref_clk),
    .button(button),
    .switch_debug(switch_debug),
    .switch_mode(switch_mode)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ----
  // Bus and compare tasks
  // ----
  task automatic chk(input [31:0] g, input [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input [31:0] a, input [31:0] d);
    int n;
    @(posedge ref_clk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    if (n >= 200) mismatches++;
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input [31:0] a);
    int n;
    @(posedge ref_clk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    if (n >= 200) mismatches++;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Counts blank cycles of both digits and relightings of the high digit
  task automatic watch(input int n);
    reg [6:0] ph;
    bh = 0;
    bl = 0;
    rh = 0;
    ph = seg_hi;
    repeat (n) begin
      @(posedge ref_clk);
      if (seg_hi === `SEG_BLANK) bh++;
      if (seg_lo === `SEG_BLANK) bl++;
      if (ph === `SEG_BLANK && seg_hi !== `SEG_BLANK) rh++;
      ph = seg_hi;
    end
  endtask

  task automatic restart;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic pause;
    repeat (WIN + 10) @(posedge ref_clk);
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Tests take about 2000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end

  // ----
  // Tests
  // ----
  initial begin
    rst = 1'b1;
    fieldbus_fail = 1'b0;
    fieldbus_tx_dir = 1'b0;
    busy = 5'h00;
    s_axi_awaddr = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 32'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(op_state, `OP_RUN);
    chk(seg_lo, 7'h3f);
    op_u.switch_mode <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(op_state, `OP_RUN);
    op_u.switch_mode <= 1'b0;
    rdr(32'hc);
    chk(rd, 32'h0);
    wr(32'h10, 32'h1);
    chk(rs, `RESP_SLVERR);
    rdr(32'h10);
    chk(rd, 32'h0);
    chk(rs, `RESP_SLVERR);
    $display("test start done");
    for (int i = 0; i < 5; i++) begin
      busy <= 5'h01 << i;
      h = 0;
      repeat (24) begin
        @(posedge ref_clk);
        if (leds[i] === 1'b1) h++;
      end
      chk(h > 2 && h < 22, 1);
      busy <= 5'h00;
      repeat (2) @(posedge ref_clk);
      chk(leds, 5'h00);
    end
    fieldbus_tx_dir <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(fieldbus_rts, 1'b1);
    $display("test indicators done");
    wr(32'hc, 32'h4);
    fieldbus_fail <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({fieldbus_fault_led, irq}, 2'h3);
    rdr(32'h8);
    chk(rd, 32'h4);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    fieldbus_fail <= 1'b0;
    wr(32'hc, 32'h3);
    chk(fieldbus_fault_led, 1'b0);
    fieldbus_fail <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(irq, 1'b0);
    rdr(32'h8);
    chk(rd, 32'h4);
    fieldbus_fail <= 1'b0;
    $display("test interrupt done");
    op_u.dbl();
    watch(20);
    chk(bh > 0 && bh < 20 && bl == 0, 1);
    op_u.click();
    pause();
    op_u.hold();
    watch(20);
    chk(bh == 0 && bl > 0 && bl < 20, 1);
    op_u.dbl();
    pause();
    fork
      op_u.hold();
      watch(140);
    join
    chk(rh, 3);
    chk(slave_address, 7'h0c);
    chk({seg_hi, seg_lo}, {7'h06, 7'h5b});
    chk(irq, 1'b1);
    rdr(32'h8);
    chk(rd, 32'h1);
    $display("test edit done");
    op_u.dbl();
    op_u.click();
    repeat (IDLE + 40) @(posedge ref_clk);
    watch(20);
    chk(bh + bl, 0);
    chk({slave_address, seg_hi}, {7'h0c, 7'h06});
    rdr(32'h8);
    chk(rd, 32'h2);
    $display("test timeout done");
    op_u.dbl();
    pause();
    repeat (8) begin
      op_u.click();
      pause();
    end
    op_u.hold();
    repeat (8) begin
      op_u.click();
      pause();
    end
    op_u.hold();
    repeat (40) @(posedge ref_clk);
    chk(slave_address, 7'h5a);
    $display("test wrap done");
    op_u.switch_mode <= 1'b1;
    restart();
    chk(op_state, `OP_CONFIG);
    chk({seg_hi, seg_lo}, {`SEG_C, `SEG_F});
    op_u.switch_mode <= 1'b0;
    op_u.switch_debug <= 1'b1;
    restart();
    op_u.dbl();
    pause();
    rdr(32'h4);
    chk(rd[13:12], 2'h0);
    rdr(32'h0);
    chk(rd, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(32'h0, m);
      chk(rs, `RESP_OKAY);
      rdr(32'h0);
      chk(rd, (m == 3) ? 32'h2 : m);
      chk(serial_mode, (m == 3) ? 2'h2 : m);
      chk({seg_hi, seg_lo}, {`SEG_D, `SEG_B});
    end
    $display("test modes done");
    finish_test();
  end
endmodule // panel_address_mode_control_tb
